//--- verilog/fbp_host_ctrl.sv
// Host controller: bypass entry, program, exit and status polling of a NOR flash
module fbp_host_ctrl (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Flash pins
    output logic [23:0] flashAddr,
    output logic [15:0] flashDout,
    output logic flashDoutEn,
    output logic flashCe_n,
    output logic flashOe_n,
    output logic flashWe_n,
    input wire logic [15:0] flashDin
);
    typedef enum logic [3:0] {
        H_IDLE = 4'b0000,
        H_WR1 = 4'b0001,
        H_WR2 = 4'b0010,
        H_WR3 = 4'b0011,
        H_POLL_A = 4'b0100,
        H_POLL_B = 4'b0101,
        H_FINAL = 4'b0110,
        H_WAIT = 4'b0111,
        H_RD = 4'b1000,
        H_PRIME = 4'b1001
    } fbp_hstate_type;

    ////////////////////////////////////////////////////////////////////////////
    logic rstMeta, rstSync_n;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta <= 1'b0;
            rstSync_n <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync_n <= rstMeta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer state
    fbp_hstate_type state, next_state, retState, next_retState;
    logic [23:0] tgtAddr, next_tgtAddr;
    logic [15:0] tgtData, next_tgtData;
    logic [15:0] firstRd, next_firstRd;
    logic [15:0] lastRd, next_lastRd;
    logic [5:0] stat, next_stat;
    logic [2:0] cmd, next_cmd;
    logic bcStart, bcWrite, bcDone;
    logic [23:0] bcAddr;
    logic [15:0] bcWdata, bcRdata;
    fbp_pkg::fbp_pins_type pins;
    // AHB
    logic dpValid, dpWrite, next_dpValid, next_dpWrite;
    logic [7:0] dpAddr, next_dpAddr;
    logic [31:0] next_hrdata;
    logic wrCtrl, wrAddr, wrData;

    function automatic logic toggled(input logic [15:0] a, input logic [15:0] b,
                                     input int bitPos);
        toggled = a[bitPos] ^ b[bitPos];
    endfunction : toggled

    assign wrCtrl = dpValid && dpWrite && dpAddr == fbp_pkg::CTRL_OFS;
    assign wrAddr = dpValid && dpWrite && dpAddr == fbp_pkg::ADDR_OFS;
    assign wrData = dpValid && dpWrite && dpAddr == fbp_pkg::DATA_OFS;

    always_comb begin
        next_state = state;
        next_retState = retState;
        next_tgtAddr = wrAddr ? hwdata[23:0] : tgtAddr;
        next_tgtData = wrData ? hwdata[15:0] : tgtData;
        next_firstRd = firstRd;
        next_lastRd = lastRd;
        next_stat = stat;
        next_cmd = cmd;
        bcStart = 1'b0;
        bcWrite = 1'b1;
        bcAddr = tgtAddr;
        bcWdata = tgtData;
        case (state)
            H_IDLE: begin
                if (wrCtrl && hwdata[2:0] != 3'h0) begin
                    next_cmd = hwdata[2:0];
                    next_stat[fbp_pkg::ST_BUSY] = 1'b1;
                    next_stat[fbp_pkg::ST_DONE] = 1'b0;
                    next_stat[fbp_pkg::ST_FAIL] = 1'b0;
                    next_stat[fbp_pkg::ST_ABORT] = 1'b0;
                    next_stat[fbp_pkg::ST_TIMEOUT] = 1'b0;
                    next_state = H_WR1;
                    if (hwdata[2:0] == fbp_pkg::CMD_READ) begin
                        next_state = H_RD;
                    end else if (hwdata[2:0] == fbp_pkg::CMD_POLL) begin
                        next_state = H_PRIME;
                    end
                end
            end
            H_WR1: begin
                bcStart = 1'b1;
                case (cmd)
                    fbp_pkg::CMD_ENTER: begin
                        bcAddr = fbp_pkg::A_UNLK1;
                        bcWdata = fbp_pkg::D_UNLK1;
                    end
                    fbp_pkg::CMD_PROG: begin
                        // Setup word, no unlock cycles
                        bcWdata = fbp_pkg::D_PSETUP;
                    end
                    default: begin
                        bcWdata = fbp_pkg::D_EXIT1;
                    end
                endcase
                next_retState = H_WR2;
                next_state = H_WAIT;
            end
            H_WR2: begin
                bcStart = 1'b1;
                next_retState = H_FINAL;
                case (cmd)
                    fbp_pkg::CMD_ENTER: begin
                        bcAddr = fbp_pkg::A_UNLK2;
                        bcWdata = fbp_pkg::D_UNLK2;
                        next_retState = H_WR3;
                    end
                    fbp_pkg::CMD_PROG: begin
                        next_retState = H_PRIME;
                    end
                    default: begin
                        bcWdata = fbp_pkg::D_EXIT2;
                        next_stat[fbp_pkg::ST_BYPASS] = 1'b0;
                    end
                endcase
                next_state = H_WAIT;
            end
            H_WR3: begin
                bcStart = 1'b1;
                bcAddr = fbp_pkg::A_UNLK1;
                bcWdata = fbp_pkg::D_ENTRY;
                next_stat[fbp_pkg::ST_BYPASS] = 1'b1;
                next_retState = H_FINAL;
                next_state = H_WAIT;
            end
            H_RD: begin
                bcStart = 1'b1;
                bcWrite = 1'b0;
                next_retState = H_FINAL;
                next_state = H_WAIT;
            end
            H_PRIME: begin
                // Fresh first read, so a stale word never pairs with status
                bcStart = 1'b1;
                bcWrite = 1'b0;
                bcAddr = tgtAddr;
                next_retState = H_POLL_A;
                next_state = H_WAIT;
            end
            H_POLL_A: begin
                // Status read at target address, strobes recycled each time
                bcStart = 1'b1;
                bcWrite = 1'b0;
                next_retState = H_POLL_B;
                next_state = H_WAIT;
            end
            H_POLL_B: begin
                if (!toggled(firstRd, lastRd, fbp_pkg::TOG1_BIT)) begin
                    // Data only from a fresh read after toggling stops
                    next_retState = H_FINAL;
                    bcStart = 1'b1;
                    bcWrite = 1'b0;
                    next_state = H_WAIT;
                end else if (lastRd[fbp_pkg::ABRT_BIT]) begin
                    next_stat[fbp_pkg::ST_ABORT] = 1'b1;
                    next_stat[fbp_pkg::ST_FAIL] = 1'b1;
                    next_state = H_FINAL;
                end else if (lastRd[fbp_pkg::TOUT_BIT]) begin
                    // Recheck once: toggle may have stopped as timeout rose
                    next_stat[fbp_pkg::ST_TIMEOUT] = 1'b1;
                    next_state = H_POLL_A;
                end else begin
                    next_state = H_POLL_A;
                end
            end
            H_WAIT: begin
                if (bcDone) begin
                    next_firstRd = lastRd;
                    next_lastRd = bcRdata;
                    if (retState == H_POLL_B && state == H_WAIT && stat[fbp_pkg::ST_TIMEOUT]
                        && toggled(lastRd, bcRdata, fbp_pkg::TOG1_BIT)) begin
                        next_stat[fbp_pkg::ST_FAIL] = 1'b1;
                        next_state = H_FINAL;
                    end else begin
                        next_state = retState;
                    end
                end
            end
            H_FINAL: begin
                if (cmd == fbp_pkg::CMD_PROG || cmd == fbp_pkg::CMD_POLL) begin
                    // For a program, the polling bit must match the data written
                    if (lastRd[fbp_pkg::POLL_BIT] != tgtData[fbp_pkg::POLL_BIT]
                        && cmd == fbp_pkg::CMD_PROG) begin
                        next_stat[fbp_pkg::ST_FAIL] = 1'b1;
                    end
                end
                next_stat[fbp_pkg::ST_BUSY] = 1'b0;
                next_stat[fbp_pkg::ST_DONE] = 1'b1;
                next_state = H_IDLE;
            end
            default: begin
                next_state = H_IDLE;
            end
        endcase
        if (state == H_IDLE && wrCtrl && hwdata[2:0] == fbp_pkg::CMD_POLL) begin
            next_lastRd = 16'h0000;
        end
    end

    always_ff @(posedge sys_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state <= H_IDLE;
            retState <= H_IDLE;
            tgtAddr <= 24'h000000;
            tgtData <= 16'h0000;
            firstRd <= 16'h0000;
            lastRd <= 16'h0000;
            stat <= 6'h00;
            cmd <= 3'h0;
        end else begin
            state <= next_state;
            retState <= next_retState;
            tgtAddr <= next_tgtAddr;
            tgtData <= next_tgtData;
            firstRd <= next_firstRd;
            lastRd <= next_lastRd;
            stat <= next_stat;
            cmd <= next_cmd;
        end
    end

    fbp_bus_cycle u_cycle (
        .sys_clk(sys_clk),
        .rstSync_n(rstSync_n),
        .start(bcStart),
        .isWrite(bcWrite),
        .addr(bcAddr),
        .wdata(bcWdata),
        .done(bcDone),
        .rdata(bcRdata),
        .pins(pins),
        .flashDin(flashDin)
    );

    assign flashAddr = pins.addr;
    assign flashDout = pins.dout;
    assign flashDoutEn = pins.doutEn;
    assign flashCe_n = pins.ceN;
    assign flashOe_n = pins.oeN;
    assign flashWe_n = pins.weN;

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait states
    always_comb begin
        next_dpValid = hsel && hready && htrans[1];
        next_dpWrite = hwrite;
        next_dpAddr = haddr;
        next_hrdata = 32'h00000000;
        if (hsel && hready && htrans[1] && !hwrite) begin
            case (haddr)
                fbp_pkg::CTRL_OFS: next_hrdata = {29'h0, cmd};
                fbp_pkg::ADDR_OFS: next_hrdata = {8'h00, tgtAddr};
                fbp_pkg::DATA_OFS: next_hrdata = {16'h0000, tgtData};
                fbp_pkg::STAT_OFS: next_hrdata = {26'h0, stat};
                fbp_pkg::RDAT_OFS: next_hrdata = {16'h0000, lastRd};
                default: next_hrdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            dpValid <= 1'b0;
            dpWrite <= 1'b0;
            dpAddr <= 8'h00;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            dpValid <= next_dpValid;
            dpWrite <= next_dpWrite;
            dpAddr <= next_dpAddr;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    sequence s_prog_setup;
        bcStart && bcWrite && bcWdata == fbp_pkg::D_PSETUP;
    endsequence

    AST_PROG_TWO_WRITES: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
        (state == H_WR2 && cmd == fbp_pkg::CMD_PROG) |-> bcWdata == tgtData)
        else $error("Bypass program second write is not target data");
    AST_PROG_SETUP: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
        (state == H_WR1 && cmd == fbp_pkg::CMD_PROG) |-> s_prog_setup)
        else $error("Program setup word wrong");
    AST_ENTRY_THIRD: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
        state == H_WR3 |-> bcAddr == fbp_pkg::A_UNLK1 && bcWdata == fbp_pkg::D_ENTRY)
        else $error("Bypass entry third write wrong");
    AST_EXIT_SECOND: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
        (state == H_WR2 && cmd == fbp_pkg::CMD_EXIT) |-> bcWdata == fbp_pkg::D_EXIT2
        ##1 !stat[fbp_pkg::ST_BYPASS])
        else $error("Bypass exit second write wrong");
    AST_ABORT_FAIL: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
        (state == H_POLL_B && toggled(firstRd, lastRd, fbp_pkg::TOG1_BIT)
         && lastRd[fbp_pkg::ABRT_BIT]) |=> stat[fbp_pkg::ST_ABORT])
        else $error("Buffer abort not reported");
endmodule : fbp_host_ctrl

//--- include/fbp_pkg.sv
// Package for the flash bypass program and status-poll host controller
package fbp_pkg;
    // Register offsets (byte addresses)
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] ADDR_OFS = 8'h04;
    localparam logic [7:0] DATA_OFS = 8'h08;
    localparam logic [7:0] STAT_OFS = 8'h0C;
    localparam logic [7:0] RDAT_OFS = 8'h10;
    // Control command codes, written to CTRL bits 2:0
    localparam logic [2:0] CMD_ENTER = 3'h1;
    localparam logic [2:0] CMD_PROG = 3'h2;
    localparam logic [2:0] CMD_EXIT = 3'h3;
    localparam logic [2:0] CMD_READ = 3'h4;
    localparam logic [2:0] CMD_POLL = 3'h5;
    // Status fields
    localparam int ST_BUSY = 0;
    localparam int ST_BYPASS = 1;
    localparam int ST_DONE = 2;
    localparam int ST_FAIL = 3;
    localparam int ST_ABORT = 4;
    localparam int ST_TIMEOUT = 5;
    // Data bus bit positions
    localparam int POLL_BIT = 7;
    localparam int TOG1_BIT = 6;
    localparam int TOUT_BIT = 5;
    localparam int ABRT_BIT = 1;
    // Flash command words and addresses
    localparam logic [15:0] D_UNLK1 = 16'h00AA;
    localparam logic [15:0] D_UNLK2 = 16'h0055;
    localparam logic [15:0] D_ENTRY = 16'h0020;
    localparam logic [15:0] D_PSETUP = 16'h00A0;
    localparam logic [15:0] D_EXIT1 = 16'h0090;
    localparam logic [15:0] D_EXIT2 = 16'h0000;
    localparam logic [23:0] A_UNLK1 = 24'h000555;
    localparam logic [23:0] A_UNLK2 = 24'h0002AA;
    // Bus cycle timing, in ns, and derived cycles at 5 ns
    localparam int CLK_NS = 5;
    localparam int STROBE_NS = 35;
    localparam int RECOV_NS = 20;
    localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] RECOV_CYC = 4'((RECOV_NS + CLK_NS - 1) / CLK_NS);

    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] dout;
        logic doutEn;
        logic ceN;
        logic oeN;
        logic weN;
    } fbp_pins_type;

    typedef enum logic [1:0] {
        BC_IDLE = 2'b00,
        BC_STROBE = 2'b01,
        BC_RECOVER = 2'b10
    } fbp_bc_state_type;
endpackage : fbp_pkg

//--- verilog/fbp_bus_cycle.sv
// One asynchronous flash write or read cycle with strobe timing
module fbp_bus_cycle (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstSync_n,
    // Request
    input wire logic start,
    input wire logic isWrite,
    input wire logic [23:0] addr,
    input wire logic [15:0] wdata,
    output logic done,
    output logic [15:0] rdata,
    // Flash pins
    output fbp_pkg::fbp_pins_type pins,
    input wire logic [15:0] flashDin
);
    fbp_pkg::fbp_bc_state_type state, next_state;
    logic [3:0] cnt, next_cnt;
    fbp_pkg::fbp_pins_type next_pins;
    logic next_done;
    logic [15:0] next_rdata;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_pins = pins;
        next_done = 1'b0;
        next_rdata = rdata;
        case (state)
            fbp_pkg::BC_IDLE: begin
                if (start) begin
                    next_pins.addr = addr;
                    next_pins.dout = wdata;
                    next_pins.doutEn = isWrite;
                    next_pins.ceN = 1'b0;
                    next_pins.oeN = isWrite;
                    next_pins.weN = ~isWrite;
                    next_cnt = fbp_pkg::STROBE_CYC;
                    next_state = fbp_pkg::BC_STROBE;
                end
            end
            fbp_pkg::BC_STROBE: begin
                if (cnt > 4'h1) begin
                    next_cnt = cnt - 4'h1;
                end else begin
                    // Final write edge: status valid from here on
                    next_rdata = flashDin;
                    next_pins.ceN = 1'b1;
                    next_pins.oeN = 1'b1;
                    next_pins.weN = 1'b1;
                    next_cnt = fbp_pkg::RECOV_CYC;
                    next_state = fbp_pkg::BC_RECOVER;
                end
            end
            fbp_pkg::BC_RECOVER: begin
                // Data held past the write edge, then released
                next_pins.doutEn = 1'b0;
                if (cnt > 4'h1) begin
                    next_cnt = cnt - 4'h1;
                end else begin
                    next_done = 1'b1;
                    next_state = fbp_pkg::BC_IDLE;
                end
            end
            default: begin
                next_state = fbp_pkg::BC_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state <= fbp_pkg::BC_IDLE;
            cnt <= 4'h0;
            pins <= '{addr: 24'h000000, dout: 16'h0000, doutEn: 1'b0,
                      ceN: 1'b1, oeN: 1'b1, weN: 1'b1};
            done <= 1'b0;
            rdata <= 16'h0000;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            pins <= next_pins;
            done <= next_done;
            rdata <= next_rdata;
        end
    end

    // Strobes released between any two cycles
    AST_STROBE_RELEASE: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
        done |-> (pins.ceN && pins.oeN && pins.weN))
        else $error("Strobes not released at end of cycle");
endmodule : fbp_bus_cycle

//--- verif/fbp_flash_model.sv
// Behavioural flash device model: bypass commands, program and status bits
module fbp_flash_model (
    // Flash pins
    input wire logic [23:0] addr,
    input wire logic [15:0] din,
    input wire logic ceN,
    input wire logic oeN,
    input wire logic weN,
    // Data towards host
    output logic [15:0] dout
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [256];
    logic [15:0] pData, rd;
    logic [1:0] unlk;
    logic inBypass, setup, exitArm, busy, tog, protect, tmoMode, abtMode;
    int busyReads, busyLeft, wrCount, rdCount;
    wire logic rdEn = !ceN && !oeN;
    wire logic wrEn = !ceN && !weN;
    // Released bus shows the inverse, never a stale word
    assign dout = rdEn ? rd : ~rd;
    initial begin
        foreach (mem[i]) mem[i] = 16'hFFFF;
        {unlk, inBypass, setup, exitArm, busy, tog, protect, tmoMode, abtMode} = '0;
        rd = 16'h0000;
        busyReads = 1;
        wrCount = 0;
        rdCount = 0;
    end
    // Latch at whichever strobe rises first: both rise on one edge
    always @(negedge wrEn) begin
        wrCount++;
        if (setup) begin
            setup = 1'h0;
            if (!protect) mem[addr[7:0]] = din;
            pData = din;
            busy = 1'h1;
            busyLeft = busyReads;
        end else if (inBypass) begin
            if (exitArm && din[7:0] == 8'h00) inBypass = 1'h0;
            exitArm = (din[7:0] == 8'h90);
            setup = (din == 16'h00A0);
        end else begin
            if (unlk == 2'h0 && addr[10:0] == 11'h555 && din == 16'h00AA) unlk = 2'h1;
            else if (unlk == 2'h1 && addr[10:0] == 11'h2AA && din == 16'h0055) unlk = 2'h2;
            else begin
                inBypass = (unlk == 2'h2 && addr[10:0] == 11'h555 && din == 16'h0020);
                unlk = 2'h0;
            end
        end
    end
    // Toggle moves only when a strobe is cycled
    always @(posedge rdEn) begin
        rdCount++;
        if (busy) begin
            tog = ~tog;
            rd = {8'h00, ~pData[7], tog, tmoMode, 3'h0, abtMode, 1'h0};
            busyLeft--;
            // Timeout and abort hold the device busy until cleared
            if (busyLeft <= 0 && !tmoMode && !abtMode) busy = 1'h0;
        end else begin
            rd = mem[addr[7:0]];
        end
    end
endmodule : fbp_flash_model

//--- verif/tb_fbp_host_ctrl.sv
// Self-checking testbench of the flash bypass host controller
module tb_fbp_host_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'h0;
    logic rst_n = 1'h0;
    logic hsel = 1'h0;
    logic hwrite = 1'h0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, st;
    logic hreadyout, hresp, flashDoutEn, flashCe_n, flashOe_n, flashWe_n;
    logic [23:0] flashAddr;
    logic [15:0] flashDout, flashDin;
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int w0, r0;
    fbp_host_ctrl u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .flashAddr(flashAddr),
        .flashDout(flashDout), .flashDoutEn(flashDoutEn), .flashCe_n(flashCe_n),
        .flashOe_n(flashOe_n), .flashWe_n(flashWe_n), .flashDin(flashDin));
    fbp_flash_model u_flash (.addr(flashAddr), .din(flashDout), .ceN(flashCe_n),
        .oeN(flashOe_n), .weN(flashWe_n), .dout(flashDin));
    always #2.5 sys_clk = ~sys_clk;
    // Hang guard, well above the expected run length
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 60000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask : chk
    function automatic logic [31:0] sb(input int i);
        return {31'h0, st[i]};
    endfunction : sb
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        hsel <= 1'h1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge sys_clk);
        while (hreadyout !== 1'h1) @(posedge sys_clk);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge sys_clk);
        while (hreadyout !== 1'h1) @(posedge sys_clk);
        q = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : ahb
    task automatic run_cmd(input logic [2:0] c);
        int n;
        n = 0;
        ahb(1'h1, fbp_pkg::CTRL_OFS, {29'h0, c}, st);
        // Status register shows busy from the edge that ends the command write
        repeat (4) @(posedge sys_clk);
        st = 32'h1;
        while (st[fbp_pkg::ST_BUSY] !== 1'h0 && n < 3000) begin
            ahb(1'h0, fbp_pkg::STAT_OFS, 32'h0, st);
            n++;
        end
        chk("busy wait", 32'h0, 32'(n >= 3000));
    endtask : run_cmd
    task automatic t_reset();
        @(posedge sys_clk);
        chk("hreadyout in reset", 32'h0, {31'h0, hreadyout});
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'h1;
        repeat (20) if (hreadyout !== 1'h1) @(posedge sys_clk);
        chk("strobes idle", 32'h7, {29'h0, flashCe_n, flashOe_n, flashWe_n});
        chk("drive off", 32'h0, {31'h0, flashDoutEn});
        ahb(1'h0, fbp_pkg::STAT_OFS, 32'h0, st);
        chk("status at reset", 32'h0, st);
        ahb(1'h1, 8'h20, 32'h5, st);
        ahb(1'h0, 8'h20, 32'h0, st);
        chk("unmapped read", 32'h0, st);
        $display("test reset done");
    endtask : t_reset
    task automatic t_enter();
        w0 = u_flash.wrCount;
        run_cmd(fbp_pkg::CMD_ENTER);
        chk("bypass flag", 32'h1, sb(fbp_pkg::ST_BYPASS));
        chk("device bypass", 32'h1, {31'h0, u_flash.inBypass});
        chk("entry writes", 32'h3, 32'(u_flash.wrCount - w0));
        $display("test enter done");
    endtask : t_enter
    task automatic t_prog(input logic [7:0] a, input logic [15:0] d, input int reads);
        u_flash.busyReads = reads;
        ahb(1'h1, fbp_pkg::ADDR_OFS, {24'h0, a}, st);
        ahb(1'h1, fbp_pkg::DATA_OFS, {16'h0, d}, st);
        w0 = u_flash.wrCount;
        r0 = u_flash.rdCount;
        run_cmd(fbp_pkg::CMD_PROG);
        chk("program fail", 32'h0, sb(fbp_pkg::ST_FAIL));
        chk("program done", 32'h1, sb(fbp_pkg::ST_DONE));
        chk("program writes", 32'h2, 32'(u_flash.wrCount - w0));
        chk("array word", {16'h0, d}, {16'h0, u_flash.mem[a]});
        chk("polled past busy", 32'h1, 32'(u_flash.rdCount - r0 > reads));
        run_cmd(fbp_pkg::CMD_READ);
        ahb(1'h0, fbp_pkg::RDAT_OFS, 32'h0, st);
        chk("read back", {16'h0, d}, st);
        run_cmd(fbp_pkg::CMD_POLL);
        chk("poll done", 32'h1, sb(fbp_pkg::ST_DONE));
        chk("poll fail", 32'h0, sb(fbp_pkg::ST_FAIL));
        ahb(1'h0, fbp_pkg::RDAT_OFS, 32'h0, st);
        chk("poll word", {16'h0, d}, st);
        $display("test program done");
    endtask : t_prog
    task automatic t_refuse();
        u_flash.busyReads = 40;
        ahb(1'h1, fbp_pkg::ADDR_OFS, 32'h78, st);
        ahb(1'h1, fbp_pkg::DATA_OFS, 32'h11, st);
        w0 = u_flash.wrCount;
        ahb(1'h1, fbp_pkg::CTRL_OFS, {29'h0, fbp_pkg::CMD_PROG}, st);
        repeat (3) @(posedge sys_clk);
        run_cmd(fbp_pkg::CMD_EXIT);
        chk("exit while busy", 32'h1, sb(fbp_pkg::ST_BYPASS));
        chk("writes while busy", 32'h2, 32'(u_flash.wrCount - w0));
        $display("test refuse done");
    endtask : t_refuse
    task automatic t_fail();
        for (int k = 0; k < 3; k++) begin
            u_flash.protect = (k == 0);
            u_flash.tmoMode = (k == 1);
            u_flash.abtMode = (k == 2);
            u_flash.busyReads = 6;
            ahb(1'h1, fbp_pkg::ADDR_OFS, 32'h56 + k, st);
            ahb(1'h1, fbp_pkg::DATA_OFS, 32'h1200, st);
            run_cmd(fbp_pkg::CMD_PROG);
            chk("fail flag", 32'h1, sb(fbp_pkg::ST_FAIL));
            if (k == 0) chk("protected word", 32'hFFFF, {16'h0, u_flash.mem[8'h56]});
            if (k == 1) chk("timeout flag", 32'h1, sb(fbp_pkg::ST_TIMEOUT));
            if (k == 2) chk("abort flag", 32'h1, sb(fbp_pkg::ST_ABORT));
            u_flash.busy = 1'h0;
        end
        {u_flash.protect, u_flash.tmoMode, u_flash.abtMode} = 3'h0;
        chk("still bypass", 32'h1, {31'h0, u_flash.inBypass});
        $display("test failures done");
    endtask : t_fail
    task automatic t_exit();
        w0 = u_flash.wrCount;
        run_cmd(fbp_pkg::CMD_EXIT);
        chk("bypass cleared", 32'h0, sb(fbp_pkg::ST_BYPASS));
        chk("device read mode", 32'h0, {31'h0, u_flash.inBypass});
        chk("exit writes", 32'h2, 32'(u_flash.wrCount - w0));
        $display("test exit done");
    endtask : t_exit
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        t_reset();
        t_enter();
        t_prog(8'h12, 16'h5A3C, 1);
        t_prog(8'h34, 16'hA5C3, 20);
        t_refuse();
        t_fail();
        t_exit();
        tally_and_finish();
    end
endmodule : tb_fbp_host_ctrl
